// [rtl/usb_drc_pkg.sv]
package usb_drc_pkg;
   // ----------------------------------------------------------------
   // Register map (byte offsets within the controller window).
   // ----------------------------------------------------------------
   localparam logic [11:0] FUNC_ADDR_OFS = 12'h000;
   localparam logic [11:0] POWER_OFS = 12'h001;
   localparam logic [11:0] INTR_OFS = 12'h00a;
   localparam logic [11:0] INTEN_OFS = 12'h00b;
   localparam logic [11:0] INDEX_OFS = 12'h00e;
   localparam logic [11:0] PHYCTL_OFS = 12'h020;
   localparam logic [11:0] EPINT_OFS = 12'h024;
   localparam logic [11:0] IDX_LO = 12'h410;
   localparam logic [11:0] IDX_HI = 12'h41f;
   localparam logic [11:0] DIR_LO = 12'h500;
   localparam logic [11:0] DIR_HI = 12'h54f;
   localparam int NUM_EP = 5;
   localparam int EP_REGS = 16;
   // Indexed sizing registers inside the 16-byte endpoint block.
   localparam logic [3:0] TXSZ_SLOT = 4'hc;
   localparam logic [3:0] RXSZ_SLOT = 4'hd;
   localparam logic [3:0] TXADR_SLOT = 4'he;
   localparam logic [3:0] RXADR_SLOT = 4'hf;
   localparam logic [7:0] EP0_FIFO_BYTES = 8'h40;
   localparam logic [12:0] FIFO_RAM_BYTES = 13'h1000;
   // ----------------------------------------------------------------
   // Power register fields.
   // ----------------------------------------------------------------
   localparam int PWR_SUSPM = 1;
   localparam int PWR_RESUME = 2;
   localparam int PWR_HS_ACTIVE = 4;
   localparam int PWR_HS_ENABLE = 5;
   localparam int PWR_SOFT_ATTACH = 6;
   // ----------------------------------------------------------------
   // Interrupt register fields.
   // ----------------------------------------------------------------
   localparam int IRQ_SUSPEND = 0;
   localparam int IRQ_RESUME = 1;
   localparam int IRQ_RESET = 2;
   localparam int IRQ_SOF = 3;
   localparam int IRQ_CONN = 4;
   localparam int IRQ_DISCON = 5;
   localparam logic [7:0] INTEN_RESET = 8'h06;
   // ----------------------------------------------------------------
   // PHY control fields.
   // ----------------------------------------------------------------
   localparam int PHY_PDWN = 0;
   localparam int PHY_OTG_PDWN = 1;
   localparam int PHY_OSCPDWN = 2;
   localparam int PHY_SESS_EN = 3;
   localparam int PHY_VBUS_DET_EN = 4;
   localparam int PHY_PLLON = 5;
   localparam int PHY_CLKSRC = 6;
   localparam int PHY_POL_SWAP = 7;
   localparam int PHY_CLKGD = 8;
   localparam logic [8:0] PHYCTL_RESET = 9'h007;
   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int SUSPEND_IDLE_US = 3000;
   localparam int SUSPEND_CYCLES = SUSPEND_IDLE_US * (CLK_HZ / 1_000_000);
   localparam int PLL_LOCK_CYCLES = 64;
   localparam int WAKE_MIN_US = 2000;
   localparam int WAKE_HOLD_US = 10000;
   localparam int WAKE_MAX_US = 15000;
   localparam int WAKE_HOLD_CYCLES = WAKE_HOLD_US * (CLK_HZ / 1_000_000);
endpackage

// [rtl/usb_drc_if.sv]
// Link between the controller and its processor-side driver.
interface usb_drc_if (
   input wire logic i_clk,
   input wire logic i_reset_n
);
   logic [11:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   logic irq;
   modport ctrl (
      input addr, wdata, wr, rd,
      output rdata, irq
   );
   modport drv (
      output addr, wdata, wr, rd,
      input rdata, irq
   );
endinterface

// [rtl/usb_drc_core.sv]
module usb_drc_core
   import usb_drc_pkg::*;
#(
   parameter int SUSP_CYC = SUSPEND_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   usb_drc_if.ctrl bus,
   input wire logic i_id_a_end,
   input wire logic i_session,
   input wire logic i_bus_activity,
   input wire logic i_bus_reset,
   input wire logic i_resume_sig,
   input wire logic i_hs_chirp_ok,
   input wire logic i_sof,
   input wire logic i_connect,
   input wire logic i_disconnect,
   input wire logic [NUM_EP-1:0] i_ep_done,
   output logic o_ext_supply_enable_out,
   output logic o_host_mode,
   output logic o_dp_pullup,
   output logic o_line_polarity_swap,
   output logic o_phy_refclk_select,
   output logic o_phy_clock_good,
   output logic o_fifo_flush
);
   // ----------------------------------------------------------------
   // Register state.
   // ----------------------------------------------------------------
   // Address and index are both zeroed by bus reset signalling.
   logic [6:0] func_addr_q;
   logic [3:0] index_q;
   // Power register bits and the suspend state of the peripheral role.
   logic soft_attach_q, resume_q, hs_enable_q, hs_active_q, susp_q;
   logic [7:0] inten_q, intr_q;
   logic [NUM_EP-1:0] epint_q;
   logic [8:0] phyctl_q;
   logic [7:0] csr_q [NUM_EP][EP_REGS];
   logic [6:0] pll_cnt_q;
   logic [31:0] idle_q;
   logic host_q;

   // Decode: indexed window uses index_q, direct window uses address.
   wire in_idx = bus.addr >= IDX_LO && bus.addr <= IDX_HI;
   wire in_dir = bus.addr >= DIR_LO && bus.addr <= DIR_HI;
   wire [3:0] dir_ep = bus.addr[7:4];
   wire [3:0] sel_ep = in_idx ? index_q : dir_ep;
   wire [3:0] slot = bus.addr[3:0];
   wire ep_ok = sel_ep < 4'(NUM_EP);
   wire csr_hit = (in_idx || in_dir) && ep_ok;
   // Endpoint 0 sizing slots are fixed and not writable.
   wire size_slot = slot >= TXSZ_SLOT;
   wire csr_wr = bus.wr && csr_hit && !(sel_ep == 4'h0 && size_slot);
   // The lock timer only runs while every power-up condition is met, so
   // a partial bring-up never reports a good clock.
   wire pll_ready = !phyctl_q[PHY_PDWN] && !phyctl_q[PHY_OTG_PDWN] &&
      !phyctl_q[PHY_OSCPDWN] && phyctl_q[PHY_SESS_EN] &&
      phyctl_q[PHY_VBUS_DET_EN] && phyctl_q[PHY_PLLON];
   wire suspend_hit = !host_q && !susp_q && idle_q >= 32'(SUSP_CYC - 1) &&
      !i_bus_activity;
   wire resume_hit = susp_q && i_resume_sig && !resume_q;
   wire [7:0] events = {2'b00, i_disconnect, i_connect, i_sof,
      i_bus_reset, resume_hit, suspend_hit};
   wire [7:0] pend_set = events & inten_q;
   wire wr_intr = bus.wr && bus.addr == INTR_OFS;
   wire wr_epint = bus.wr && bus.addr == EPINT_OFS;

   // Role is taken from the cable end; VBUS pump only as host in session.
   assign o_host_mode = host_q;
   assign o_ext_supply_enable_out = host_q && i_session;
   assign o_dp_pullup = soft_attach_q && !host_q;
   assign o_line_polarity_swap = phyctl_q[PHY_POL_SWAP];
   assign o_phy_refclk_select = phyctl_q[PHY_CLKSRC];
   assign o_phy_clock_good = phyctl_q[PHY_CLKGD];
   assign o_fifo_flush = i_bus_reset;
   assign bus.irq = |intr_q || |epint_q;

   // Read mux; reads have no side effects, status registers clear only on a write of ones.
   always_comb begin
      bus.rdata = 8'h00;
      if (csr_hit) begin
         if (sel_ep == 4'h0 && slot == TXSZ_SLOT) begin
            bus.rdata = EP0_FIFO_BYTES;
         end else begin
            bus.rdata = csr_q[sel_ep[2:0]][slot];
         end
      end else begin
         unique case (bus.addr)
            FUNC_ADDR_OFS: bus.rdata = {1'b0, func_addr_q};
            POWER_OFS: bus.rdata = {1'b0, soft_attach_q, hs_enable_q,
               hs_active_q,
               1'b0, resume_q, susp_q, 1'b0};
            INTR_OFS: bus.rdata = intr_q;
            INTEN_OFS: bus.rdata = inten_q;
            INDEX_OFS: bus.rdata = {4'h0, index_q};
            PHYCTL_OFS: bus.rdata = phyctl_q[7:0];
            PHYCTL_OFS + 12'h001: bus.rdata = {7'h00, phyctl_q[8]};
            EPINT_OFS: bus.rdata = {3'b000, epint_q};
            default: bus.rdata = 8'h00;
         endcase
      end
   end

   // Role sampling, PHY control and the PLL lock timer.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         host_q <= 1'b0;
         phyctl_q <= PHYCTL_RESET;
         pll_cnt_q <= 7'h00;
      end else begin
         host_q <= i_id_a_end;
         if (bus.wr && bus.addr == PHYCTL_OFS) begin
            phyctl_q[7:0] <= bus.wdata;
         end
         if (!pll_ready) begin
            pll_cnt_q <= 7'h00;
            phyctl_q[PHY_CLKGD] <= 1'b0;
         end else if (pll_cnt_q == 7'(PLL_LOCK_CYCLES - 1)) begin
            phyctl_q[PHY_CLKGD] <= 1'b1;
         end else begin
            pll_cnt_q <= pll_cnt_q + 7'h01;
         end
      end
   end

   // Function address, index, power register and suspend tracking.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         func_addr_q <= 7'h00;
         index_q <= 4'h0;
         soft_attach_q <= 1'b0;
         resume_q <= 1'b0;
         hs_enable_q <= 1'b0;
         hs_active_q <= 1'b0;
         susp_q <= 1'b0;
         idle_q <= 32'h0;
      end else if (i_bus_reset) begin
         func_addr_q <= 7'h00;
         index_q <= 4'h0;
         hs_active_q <= hs_enable_q && i_hs_chirp_ok;
         susp_q <= 1'b0;
         idle_q <= 32'h0;
      end else begin
         if (bus.wr && bus.addr == FUNC_ADDR_OFS) begin
            func_addr_q <= bus.wdata[6:0];
         end
         if (bus.wr && bus.addr == INDEX_OFS) index_q <= bus.wdata[3:0];
         if (bus.wr && bus.addr == POWER_OFS) begin
            soft_attach_q <= bus.wdata[PWR_SOFT_ATTACH];
            hs_enable_q <= bus.wdata[PWR_HS_ENABLE];
            resume_q <= bus.wdata[PWR_RESUME] && susp_q;
         end
         // The idle count is held at zero while suspended, so that a
         // resume starts a fresh idle period instead of falling straight
         // back into suspend on a stale count.
         idle_q <= (i_bus_activity || susp_q) ? 32'h0 : idle_q + 32'h1;
         if (suspend_hit) begin
            susp_q <= 1'b1;
         end else if (resume_hit || i_bus_activity) begin
            susp_q <= 1'b0;
         end
      end
   end

   // Sticky interrupt flags; a new event wins over a clearing write.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         inten_q <= INTEN_RESET;
         intr_q <= 8'h00;
         epint_q <= '0;
      end else begin
         if (bus.wr && bus.addr == INTEN_OFS) inten_q <= bus.wdata;
         intr_q <= (wr_intr ? intr_q & ~bus.wdata : intr_q) | pend_set;
         epint_q <= (wr_epint ? epint_q & ~bus.wdata[NUM_EP-1:0] : epint_q)
            | i_ep_done;
      end
   end

   // Endpoint register blocks, cleared on bus reset.
   for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      for (genvar r = 0; r < EP_REGS; r++) begin : g_reg
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               csr_q[e][r] <= 8'h00;
            end else if (i_bus_reset) begin
               csr_q[e][r] <= 8'h00;
            end else if (csr_wr && sel_ep == 4'(e) && slot == 4'(r)) begin
               csr_q[e][r] <= bus.wdata;
            end
         end
      end
   end
endmodule

// [rtl/usb_drc_driver.sv]
module usb_drc_driver
   import usb_drc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   usb_drc_if.drv bus,
   input wire logic i_req_wr,
   input wire logic i_req_rd,
   input wire logic [11:0] i_req_addr,
   input wire logic [7:0] i_req_wdata,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_irq
);
   // Strobes are forwarded, a read dropped under a same-cycle write; other rules
   // are kept by the software issuing requests.
   assign bus.addr = i_req_addr;
   assign bus.wdata = i_req_wdata;
   assign bus.wr = i_req_wr;
   assign bus.rd = i_req_rd && !i_req_wr;
   assign o_irq = bus.irq;

   // Read data is captured the cycle of the strobe.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= bus.rd;
         if (bus.rd) o_rdata <= bus.rdata;
      end
   end
endmodule

// [test/usb_drc_monitor.sv]
module usb_drc_monitor
   import usb_drc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic irq,
   input wire logic i_id_a_end,
   input wire logic i_session,
   input wire logic i_bus_reset,
   input wire logic o_ext_supply_enable_out,
   input wire logic o_host_mode,
   input wire logic o_dp_pullup,
   input wire logic o_line_polarity_swap,
   input wire logic o_phy_refclk_select,
   input wire logic o_fifo_flush
);
   // ----------------------------------------------------------------
   // Port checks
   // ----------------------------------------------------------------
   // One clock domain, so clocking and reset are stated once here.
   default clocking mon_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   host_supply_a: assert property (
      o_host_mode && i_session |-> o_ext_supply_enable_out)
      else $error("supply enable low in a host session");
   periph_supply_a: assert property (
      !o_host_mode |-> !o_ext_supply_enable_out)
      else $error("supply enable high in peripheral role");
   nosess_supply_a: assert property (
      !i_session |-> !o_ext_supply_enable_out)
      else $error("supply enable high without a session");
   role_follow_a: assert property (
      i_id_a_end == $past(i_id_a_end) |=> o_host_mode == $past(i_id_a_end))
      else $error("role does not follow the cable end");
   attach_write_a: assert property (
      wr && addr == POWER_OFS && !i_id_a_end && !o_host_mode && !i_bus_reset
      |=> o_dp_pullup == $past(wdata[PWR_SOFT_ATTACH]))
      else $error("pull-up does not follow the attach bit");
   flush_follow_a: assert property (
      o_fifo_flush == i_bus_reset)
      else $error("fifo flush does not track bus reset");
   polarity_write_a: assert property (
      wr && addr == PHYCTL_OFS |=> o_line_polarity_swap == $past(wdata[7]))
      else $error("polarity swap does not follow its bit");
   refclk_write_a: assert property (
      wr && addr == PHYCTL_OFS |=> o_phy_refclk_select == $past(wdata[6]))
      else $error("reference select does not follow its bit");
   reset_irq_a: assert property (
      $rose(i_bus_reset) |-> ##[1:3] irq)
      else $error("no interrupt after bus reset");
endmodule

// [test/usb_dual_role_core_control_test.sv]
module usb_dual_role_core_control_test
   import usb_drc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Stimulus and design
   // ----------------------------------------------------------------
   // A short idle count keeps the suspend scenarios quick.
   localparam int SC = 50;
   logic i_clk = 0, i_reset_n = 0, id = 0, sess = 0, act = 1, brst = 0;
   logic res = 0, hs = 0, sof = 0, conn = 0, disc = 0, wr = 0, rd = 0;
   logic [4:0] epd = '0;
   logic [11:0] adr = '0;
   logic [7:0] wd = '0;
   logic [7:0] rdata;
   logic sup, host, pull, pol, rsel, gd, flush, rvalid, irq;
   int errors = 0, n_checks = 0, seed = 11479, cyc = 0, v;
   usb_drc_if bus (.i_clk(i_clk), .i_reset_n(i_reset_n));
   usb_drc_core #(.SUSP_CYC(SC)) u_usb_drc_core (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .bus(bus), .i_id_a_end(id), .i_session(sess),
      .i_bus_activity(act), .i_bus_reset(brst), .i_resume_sig(res),
      .i_hs_chirp_ok(hs), .i_sof(sof), .i_connect(conn),
      .i_disconnect(disc), .i_ep_done(epd), .o_ext_supply_enable_out(sup),
      .o_host_mode(host), .o_dp_pullup(pull), .o_line_polarity_swap(pol),
      .o_phy_refclk_select(rsel), .o_phy_clock_good(gd),
      .o_fifo_flush(flush));
   usb_drc_driver u_usb_drc_driver (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .bus(bus), .i_req_wr(wr), .i_req_rd(rd), .i_req_addr(adr),
      .i_req_wdata(wd), .o_rdata(rdata), .o_rvalid(rvalid), .o_irq(irq));
   usb_drc_monitor u_usb_drc_monitor (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .irq(bus.irq),
      .i_id_a_end(id), .i_session(sess), .i_bus_reset(brst),
      .o_ext_supply_enable_out(sup), .o_host_mode(host), .o_dp_pullup(pull),
      .o_line_polarity_swap(pol), .o_phy_refclk_select(rsel),
      .o_fifo_flush(flush));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Each access starts on a fresh edge so no strobe is set twice at once.
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
      @(negedge i_clk);
   endtask
   // A read that misses its valid strobe is compared as unknown.
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] e,
                         input logic [7:0] m = 8'hff);
      @(posedge i_clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      @(negedge i_clk);
      check(rvalid === 1'b1 ? rdata & m : 8'hxx, e);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------------------------------
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   // The whole run needs a few hundred cycles; this cuts a hang short.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rd_reg(PHYCTL_OFS, PHYCTL_RESET[7:0]);
      rd_reg(POWER_OFS, 8'h00);
      rd_reg(12'h300, 8'h00);
      check({7'h0, gd}, 8'h00);
      wr_reg(PHYCTL_OFS, 8'hf8);
      check({6'h0, rsel, pol}, 8'h03);
      repeat (PLL_LOCK_CYCLES + 4) @(posedge i_clk);
      rd_reg(PHYCTL_OFS + 12'h1, 8'h01);
      check({7'h0, gd}, 8'h01);
      wr_reg(PHYCTL_OFS, 8'h38);
      check({6'h0, rsel, pol}, 8'h00);
      $display("phy bring-up test done");
      for (int i = 0; i < 16; i++) begin
         @(posedge i_clk);
         id <= 1'($random(seed));
         sess <= 1'($random(seed));
         repeat (2) @(negedge i_clk);
         check({host, sup}, {id, id & sess});
      end
      @(posedge i_clk);
      id <= 1'b0;
      $display("role test done");
      for (int ep = 0; ep < NUM_EP; ep++) begin
         v = $random(seed) & 'hff;
         wr_reg(INDEX_OFS, 8'(ep));
         wr_reg(IDX_LO + 12'(TXSZ_SLOT), 8'(v));
         wr_reg(IDX_LO + 12'(TXADR_SLOT), 8'(v));
         rd_reg(IDX_LO + 12'(TXSZ_SLOT), ep ? 8'(v) : EP0_FIFO_BYTES);
         rd_reg(DIR_LO + 12'(ep * 16) + 12'(TXSZ_SLOT),
                ep ? 8'(v) : EP0_FIFO_BYTES);
         rd_reg(DIR_LO + 12'(ep * 16) + 12'(TXADR_SLOT), ep ? 8'(v) : 8'h00);
      end
      $display("endpoint window test done");
      wr_reg(POWER_OFS, 8'h40);
      check({7'h0, pull}, 8'h01);
      wr_reg(POWER_OFS, 8'h00);
      check({7'h0, pull}, 8'h00);
      wr_reg(INTEN_OFS, 8'h3f);
      for (int b = 3; b < 6; b++) begin
         @(posedge i_clk);
         {disc, conn, sof} <= 3'(1 << (b - 3));
         v = $random(seed);
         epd <= 5'(v);
         @(posedge i_clk);
         {disc, conn, sof} <= 3'h0;
         epd <= 5'h0;
         rd_reg(INTR_OFS, 8'(1 << b));
         check({7'h0, irq}, 8'h01);
         rd_reg(EPINT_OFS, {3'h0, 5'(v)});
         wr_reg(INTR_OFS, 8'hff);
         wr_reg(EPINT_OFS, 8'hff);
      end
      $display("attach and event test done");
      @(posedge i_clk);
      act <= 1'b0;
      repeat (SC + 4) @(posedge i_clk);
      rd_reg(POWER_OFS, 8'h02);
      rd_reg(INTR_OFS, 8'h01);
      @(posedge i_clk);
      res <= 1'b1;
      repeat (3) @(posedge i_clk);
      res <= 1'b0;
      rd_reg(POWER_OFS, 8'h00);
      rd_reg(INTR_OFS, 8'h03);
      repeat (SC + 4) @(posedge i_clk);
      wr_reg(INTR_OFS, 8'hff);
      wr_reg(POWER_OFS, 8'h04);
      @(posedge i_clk);
      res <= 1'b1;
      repeat (20) @(posedge i_clk);
      res <= 1'b0;
      wr_reg(POWER_OFS, 8'h00);
      rd_reg(INTR_OFS, 8'h00, 8'h02);
      @(posedge i_clk);
      act <= 1'b1;
      $display("suspend test done");
      for (int h = 0; h < 2; h++) begin
         wr_reg(FUNC_ADDR_OFS, 8'h2a);
         wr_reg(INDEX_OFS, 8'h03);
         wr_reg(POWER_OFS, 8'(h << PWR_HS_ENABLE));
         @(posedge i_clk);
         brst <= 1'b1;
         hs <= 1'b1;
         @(negedge i_clk);
         check({7'h0, flush}, 8'h01);
         repeat (4) @(posedge i_clk);
         brst <= 1'b0;
         rd_reg(FUNC_ADDR_OFS, 8'h00);
         rd_reg(INDEX_OFS, 8'h00);
         rd_reg(INTR_OFS, 8'h04, 8'h04);
         rd_reg(POWER_OFS, 8'(h << PWR_HS_ACTIVE), 8'h10);
         wr_reg(INTR_OFS, 8'hff);
      end
      $display("bus reset test done");
      conclude();
   end
endmodule
